/* File: design/pin_sync.sv */
// two-flop synchroniser for a group of pin levels
// assumes each bit is a slowly changing level or a clock well below clk_sys
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// levels
	input wire logic [W-1:0] async,
	output logic [W-1:0] synced
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} sync_t;
	sync_t q_reg, q_next;
	// first stage feeds only the second
	always_comb begin
		q_next.stage1 = async;
		q_next.stage2 = q_reg.stage1;
	end
	always_ff @(posedge clk_sys) begin
		q_reg <= rst ? {INIT, INIT} : q_next;
	end
	assign synced = q_reg.stage2;
endmodule : pin_sync

/* File: design/serial_link_slave.sv */
// serial programming port: frame shifter, address filter, read data driver
// assumes sclk, selN and sdi already synchronised to clk_sys
`timescale 1ns/1ps
module serial_link_slave
	import synth_ctrl_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// link levels
	input wire logic sclk,
	input wire logic selN,
	input wire logic sdi,
	// configuration
	input wire logic addrFilter,
	input wire logic [1:0] myAddr,
	input wire logic [15:0] readWord,
	// register side
	output logic [4:0] regIdx,
	output logic [15:0] wrData,
	output logic wrPulse,
	output logic sdo,
	output logic sdoActive
);
	typedef struct packed {
		logic prevSclk;
		logic [4:0] count;
		logic [7:0] hdr;
		logic [15:0] data;
		logic [15:0] outSh;
		logic sdo;
		logic active;
		logic wrPulse;
	} link_t;
	link_t q_reg, q_next;
	logic rise, fall, isRead, selected;
	assign rise = sclk & ~q_reg.prevSclk;
	assign fall = ~sclk & q_reg.prevSclk;
	assign isRead = q_reg.hdr[7];
	assign selected = ~addrFilter | (q_reg.hdr[6:5] == myAddr);
	// frame shifter and read driver
	always_comb begin
		q_next = q_reg;
		q_next.wrPulse = 1'b0;
		q_next.prevSclk = sclk;
		if (selN) begin
			q_next.count = '0;
			q_next.active = 1'b0;
		end else if (rise && q_reg.count != 5'(FRAME_BITS)) begin
			if (q_reg.count < 5'(HDR_BITS)) begin
				q_next.hdr = {q_reg.hdr[6:0], sdi};
			end else begin
				q_next.data = {q_reg.data[14:0], sdi};
			end
			q_next.count = q_reg.count + 5'h01;
			if (q_reg.count == 5'(FRAME_BITS - 1) && !isRead && selected) begin
				q_next.wrPulse = 1'b1;
			end
		end else if (fall && q_reg.count >= 5'(HDR_BITS) && isRead && selected) begin
			if (!q_reg.active) begin
				q_next.active = 1'b1;
				q_next.sdo = readWord[15];
				q_next.outSh = {readWord[14:0], 1'b0};
			end else begin
				q_next.sdo = q_reg.outSh[15];
				q_next.outSh = {q_reg.outSh[14:0], 1'b0};
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		q_reg <= rst ? '0 : q_next;
	end
	assign regIdx = q_reg.hdr[4:0];
	assign wrData = q_reg.data;
	assign wrPulse = q_reg.wrPulse;
	assign sdo = q_reg.sdo;
	assign sdoActive = q_reg.active & ~selN;
endmodule : serial_link_slave

/* File: design/synth_ctrl_pkg.sv */
// constants and register layout for the synthesizer control block
// assumes 100 MHz system clock and 16-bit registers in the low half of each 32-bit word
package synth_ctrl_pkg;
	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam int REG_LOOP = 0;
	localparam int REG_REF = 1;
	localparam int REG_IFACE = 2;
	localparam int REG_GPO = 3;
	localparam int REG_STATUS = 4;
	localparam int REG_CALPUMP = 5;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PUMP1_LSB = 0;
	localparam int PUMP2_LSB = 6;
	localparam int AUTOBW_BIT = 12;
	localparam int REFKEEP_BIT = 0;
	localparam int WAIT_LSB = 1;
	localparam int GAIN_LSB = 9;
	localparam int FOURLINE_BIT = 0;
	localparam int SWCTRL_BIT = 1;
	localparam int ADDREN_BIT = 2;
	localparam int SWEN_BIT = 3;
	localparam int SWBANK_BIT = 4;
	localparam int SWRST_BIT = 5;
	localparam int RELOCK_BIT = 6;
	localparam int PINGPO_BIT = 7;
	localparam int GPO1_LSB = 0;
	localparam int GPO2_LSB = 6;
	// ------------------------------------------------------------
	// reset values and widths
	// ------------------------------------------------------------
	localparam logic [5:0] PUMP_RESET = 6'h1F;
	localparam logic [7:0] WAIT_RESET = 8'h10;
	localparam logic [6:0] BAND_START = 7'h40;
	localparam logic [6:0] BAND_FAIL_LO = 7'h00;
	localparam logic [6:0] BAND_FAIL_HI = 7'h7F;
	// ------------------------------------------------------------
	// serial frame: read flag, 2 address bits, 5 index bits, 16 data bits
	// ------------------------------------------------------------
	localparam int HDR_BITS = 8;
	localparam int FRAME_BITS = 24;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int WARM_UNIT_NS = 1280;
	localparam int WARM_UNIT_CYCLES = WARM_UNIT_NS / CLK_PERIOD_NS;
	localparam int SETTLE_NS = 200;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// register contents
	// ------------------------------------------------------------
	typedef struct packed {
		logic [5:0] pump1;
		logic [5:0] pump2;
		logic autoBw;
		logic refKeep;
		logic [7:0] startWait;
		logic [1:0] mixGain;
		logic fourLine;
		logic swCtrl;
		logic addrEn;
		logic swEnable;
		logic swBank;
		logic swReset;
		logic relock;
		logic pinGpo;
		logic [5:0] gpo1;
		logic [5:0] gpo2;
	} regs_t;
	localparam regs_t REGS_RESET = '{pump1: PUMP_RESET, pump2: PUMP_RESET,
		startWait: WAIT_RESET, default: '0};
endpackage : synth_ctrl_pkg

/* File: design/synth_modulator_control.sv */
// digital control of a synthesizer and IQ modulator: registers, pins, band calibration
// assumes pins and analog comparators are asynchronous; AXI4-Lite on clk_sys
`timescale 1ns/1ps
module synth_modulator_control
	import synth_ctrl_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int WARMUP_UNIT_CYCLES = WARM_UNIT_CYCLES
) (
	// clock and power-on reset
	input wire logic clk_sys,
	input wire logic rst,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial link pins
	input wire logic serialClk,
	input wire logic serialSelectN,
	input wire logic serialDataPinIn,
	output logic serialDataPinOut,
	output logic serialDataPinOe,
	output logic lockOrReadDataPin,
	// control pins, bit 0 enable, bit 1 bank select
	input wire logic enablePin,
	input wire logic bankSelectPin,
	input wire logic resetPinN,
	input wire logic addressPinA,
	input wire logic addressPinB,
	output logic [1:0] ctrlPinsOut,
	output logic [1:0] ctrlPinsOe,
	// analog side
	input wire logic vcoFast,
	input wire logic tuneInWindow,
	input wire logic [5:0] vcoGainCode,
	output logic analogOn,
	output logic referenceOn,
	output logic [6:0] vcoBand,
	output logic [5:0] pumpCurrent,
	output logic [1:0] mixerGain,
	output logic [5:0] generalOutputs
);
	typedef enum logic [1:0] {CAL_IDLE, CAL_WARM, CAL_SETTLE} cal_t;
	typedef struct packed {
		regs_t regs;
		logic awHeld;
		logic wHeld;
		logic [ADDR_W-1:0] awAddr;
		logic [15:0] wData;
		logic [1:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [1:0] rResp;
		logic [15:0] rData;
		cal_t calState;
		logic [6:0] band;
		logic [6:0] trial;
		logic [7:0] settleCnt;
		logic failed;
		logic [5:0] calPump;
		logic [23:0] warmCnt;
		logic refReady;
		logic enPrev;
		logic lockFlag;
		logic ldPin;
		logic [5:0] pumpOut;
		logic [5:0] gpoOut;
	} state_t;
	// pump output starts at the field's reset value, not zero
	localparam state_t ST_RESET = '{regs: REGS_RESET, band: BAND_START, calState: CAL_IDLE,
		pumpOut: PUMP_RESET, default: '0};
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [23:0] WARM_UNIT24 = 24'(WARMUP_UNIT_CYCLES);
	localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);

	state_t q_reg, q_next;
	logic enSync, bankSync, resetNSync, fastSync, windowSync;
	logic [1:0] addrSync;
	logic [5:0] gainSync;
	logic sclkSync, selNSync, sdiSync;
	logic [4:0] linkIdx;
	logic [15:0] linkData, linkRead;
	logic linkWr, linkSdo, linkActive;

	// ------------------------------------------------------------
	// register helpers
	// ------------------------------------------------------------
	function automatic regs_t regWrite(regs_t r, logic [4:0] idx, logic [15:0] d,
		logic [15:0] m);
		logic [15:0] v;
		v = (regRead(r, idx, '0, 1'b0, '0, 1'b0, 1'b0, 1'b0) & ~m) | (d & m);
		unique case (idx)
			5'(REG_LOOP): begin
				r.pump1 = v[PUMP1_LSB +: 6];
				r.pump2 = v[PUMP2_LSB +: 6];
				r.autoBw = v[AUTOBW_BIT];
			end
			5'(REG_REF): begin
				r.refKeep = v[REFKEEP_BIT];
				r.startWait = v[WAIT_LSB +: 8];
				r.mixGain = v[GAIN_LSB +: 2];
			end
			5'(REG_IFACE): begin
				r.fourLine = v[FOURLINE_BIT];
				r.swCtrl = v[SWCTRL_BIT];
				r.addrEn = v[ADDREN_BIT];
				r.swEnable = v[SWEN_BIT];
				r.swBank = v[SWBANK_BIT];
				r.swReset = v[SWRST_BIT];
				r.relock = v[RELOCK_BIT];
				r.pinGpo = v[PINGPO_BIT];
			end
			5'(REG_GPO): begin
				r.gpo1 = v[GPO1_LSB +: 6];
				r.gpo2 = v[GPO2_LSB +: 6];
			end
			default: begin
			end
		endcase
		return r;
	endfunction : regWrite

	function automatic logic [15:0] regRead(regs_t r, logic [4:0] idx, logic [6:0] band,
		logic failed, logic [5:0] calPump, logic lock, logic refReady, logic busy);
		logic [15:0] v;
		v = '0;
		unique case (idx)
			5'(REG_LOOP): begin
				v[PUMP1_LSB +: 6] = r.pump1;
				v[PUMP2_LSB +: 6] = r.pump2;
				v[AUTOBW_BIT] = r.autoBw;
			end
			5'(REG_REF): begin
				v[REFKEEP_BIT] = r.refKeep;
				v[WAIT_LSB +: 8] = r.startWait;
				v[GAIN_LSB +: 2] = r.mixGain;
			end
			5'(REG_IFACE): begin
				v[FOURLINE_BIT] = r.fourLine;
				v[SWCTRL_BIT] = r.swCtrl;
				v[ADDREN_BIT] = r.addrEn;
				v[SWEN_BIT] = r.swEnable;
				v[SWBANK_BIT] = r.swBank;
				v[SWRST_BIT] = r.swReset;
				v[RELOCK_BIT] = r.relock;
				v[PINGPO_BIT] = r.pinGpo;
			end
			5'(REG_GPO): begin
				v[GPO1_LSB +: 6] = r.gpo1;
				v[GPO2_LSB +: 6] = r.gpo2;
			end
			5'(REG_STATUS): begin
				v = {5'h00, busy, refReady, lock, failed, band};
			end
			5'(REG_CALPUMP): begin
				v = {10'h000, calPump};
			end
			default: begin
			end
		endcase
		return v;
	endfunction : regRead

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// reset pin and select start at their idle high level
	pin_sync #(.W(16), .INIT(16'h2002)) u_pins (
		.clk_sys(clk_sys),
		.rst(rst),
		.async({enablePin, bankSelectPin, resetPinN, addressPinB, addressPinA, vcoFast,
			tuneInWindow, vcoGainCode, serialClk, serialSelectN, serialDataPinIn}),
		.synced({enSync, bankSync, resetNSync, addrSync, fastSync, windowSync, gainSync,
			sclkSync, selNSync, sdiSync})
	);

	serial_link_slave u_link (
		.clk_sys(clk_sys),
		.rst(rst),
		.sclk(sclkSync),
		.selN(selNSync),
		.sdi(sdiSync),
		.addrFilter(q_reg.regs.addrEn),
		.myAddr(addrSync),
		.readWord(linkRead),
		.regIdx(linkIdx),
		.wrData(linkData),
		.wrPulse(linkWr),
		.sdo(linkSdo),
		.sdoActive(linkActive)
	);

	// ------------------------------------------------------------
	// effective controls
	// ------------------------------------------------------------
	logic effEn, effBank, softReset, calStart, busy;
	logic [ADDR_W-3:0] awIdx, arIdx;
	assign effEn = q_reg.regs.swCtrl ? q_reg.regs.swEnable : enSync;
	assign effBank = q_reg.regs.swCtrl ? q_reg.regs.swBank : bankSync;
	assign softReset = q_reg.regs.swCtrl ? q_reg.regs.swReset : ~resetNSync;
	// enable rise or re-lock starts calibration
	assign calStart = effEn & (~q_reg.enPrev | q_reg.regs.relock);
	assign busy = q_reg.calState != CAL_IDLE;
	assign awIdx = q_reg.awAddr[ADDR_W-1:2];
	assign arIdx = s_axi_araddr[ADDR_W-1:2];
	assign linkRead = regRead(q_reg.regs, linkIdx, q_reg.band, q_reg.failed, q_reg.calPump,
		q_reg.lockFlag, q_reg.refReady, busy);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		q_next = q_reg;
		q_next.enPrev = effEn;
		q_next.regs.relock = 1'b0;
		// bus write channels
		if (s_axi_awvalid && s_axi_awready) begin
			q_next.awHeld = 1'b1;
			q_next.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			q_next.wHeld = 1'b1;
			q_next.wData = s_axi_wdata[15:0];
			q_next.wStrb = s_axi_wstrb[1:0];
		end
		if (q_reg.bValid && s_axi_bready) begin
			q_next.bValid = 1'b0;
		end
		if (q_reg.awHeld && q_reg.wHeld && !q_reg.bValid) begin
			q_next.awHeld = 1'b0;
			q_next.wHeld = 1'b0;
			q_next.bValid = 1'b1;
			q_next.bResp = (awIdx > (ADDR_W-2)'(REG_CALPUMP)) ? RESP_SLVERR : RESP_OKAY;
			if (awIdx <= (ADDR_W-2)'(REG_GPO)) begin
				q_next.regs = regWrite(q_next.regs, 5'(awIdx), q_reg.wData,
					{{8{q_reg.wStrb[1]}}, {8{q_reg.wStrb[0]}}});
			end
		end
		// serial write, filtered in the link
		if (linkWr) begin
			q_next.regs = regWrite(q_next.regs, linkIdx, linkData, 16'hFFFF);
		end
		// bus read channel
		if (q_reg.rValid && s_axi_rready) begin
			q_next.rValid = 1'b0;
		end
		if (s_axi_arvalid && !q_reg.rValid) begin
			q_next.rValid = 1'b1;
			q_next.rResp = (arIdx > (ADDR_W-2)'(REG_CALPUMP)) ? RESP_SLVERR : RESP_OKAY;
			q_next.rData = regRead(q_reg.regs, 5'(arIdx), q_reg.band, q_reg.failed,
				q_reg.calPump, q_reg.lockFlag, q_reg.refReady, busy);
		end
		if (!(effEn || q_reg.regs.refKeep)) begin
			q_next.warmCnt = '0;
			q_next.refReady = 1'b0;
		end else if (!q_reg.refReady) begin
			if (q_reg.warmCnt >= 24'(q_reg.regs.startWait) * WARM_UNIT24) begin
				q_next.refReady = 1'b1;
			end else begin
				q_next.warmCnt = q_reg.warmCnt + 24'h000001;
			end
		end
		// band search, one bit per settle period
		unique case (q_reg.calState)
			CAL_IDLE: begin
			end
			CAL_WARM: begin
				q_next.settleCnt = '0;
				if (q_reg.refReady) begin
					q_next.calState = CAL_SETTLE;
				end
			end
			CAL_SETTLE: begin
				q_next.settleCnt = q_reg.settleCnt + 8'h01;
				if (q_reg.settleCnt == SETTLE_LAST) begin
					q_next.settleCnt = '0;
					q_next.band = fastSync ? q_reg.band : (q_reg.band & ~q_reg.trial);
					q_next.trial = q_reg.trial >> 1;
					q_next.band = q_next.band | q_next.trial;
					if (q_reg.trial[0]) begin
						q_next.calState = CAL_IDLE;
						q_next.failed = (q_next.band == BAND_FAIL_LO) ||
							(q_next.band == BAND_FAIL_HI);
						q_next.calPump = ~gainSync;
					end
				end
			end
		endcase
		if (!effEn) begin
			q_next.calState = CAL_IDLE;
		end else if (calStart) begin
			q_next.calState = CAL_WARM;
			q_next.band = BAND_START;
			q_next.trial = BAND_START;
			q_next.failed = 1'b0;
		end
		q_next.lockFlag = windowSync & effEn & (q_reg.calState == CAL_IDLE);
		// lock pin carries read data in four-line mode
		q_next.ldPin = (q_reg.regs.fourLine && linkActive) ? linkSdo : q_reg.lockFlag;
		q_next.pumpOut = q_reg.regs.autoBw ? q_reg.calPump :
			(effBank ? q_reg.regs.pump2 : q_reg.regs.pump1);
		q_next.gpoOut = effBank ? q_reg.regs.gpo2 : q_reg.regs.gpo1;
		// reset pin or bit restores startup state
		if (softReset) begin
			q_next.regs = REGS_RESET;
			q_next.calState = CAL_IDLE;
			q_next.band = BAND_START;
			q_next.failed = 1'b0;
			q_next.calPump = '0;
			q_next.warmCnt = '0;
			q_next.refReady = 1'b0;
			q_next.lockFlag = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		q_reg <= rst ? ST_RESET : q_next;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready = ~q_reg.awHeld & ~q_reg.bValid;
	assign s_axi_wready = ~q_reg.wHeld & ~q_reg.bValid;
	assign s_axi_bvalid = q_reg.bValid;
	assign s_axi_bresp = q_reg.bResp;
	assign s_axi_arready = ~q_reg.rValid;
	assign s_axi_rvalid = q_reg.rValid;
	assign s_axi_rresp = q_reg.rResp;
	assign s_axi_rdata = {16'h0000, q_reg.rData};
	// three-line mode reads back on the data pin
	assign serialDataPinOut = linkSdo;
	assign serialDataPinOe = linkActive & ~q_reg.regs.fourLine;
	assign lockOrReadDataPin = q_reg.ldPin;
	assign ctrlPinsOut = q_reg.gpoOut[1:0];
	assign ctrlPinsOe = {2{q_reg.regs.swCtrl & q_reg.regs.pinGpo}};
	assign analogOn = q_reg.enPrev;
	assign referenceOn = q_reg.enPrev | q_reg.regs.refKeep;
	assign vcoBand = q_reg.band;
	assign pumpCurrent = q_reg.pumpOut;
	assign mixerGain = q_reg.regs.mixGain;
	assign generalOutputs = q_reg.gpoOut;
endmodule : synth_modulator_control

/* File: sim/serial_host_model.sv */
// host model on the serial programming link, 80 ns link clock
// assumes the bench resolves the shared data line from the device's output enable
`timescale 1ns/1ps
module serial_host_model (
	// link outputs
	output logic sclk,
	output logic selN,
	output logic sdi,
	// line levels seen
	input wire logic dataLine,
	input wire logic readLine
);
	// idle link, clock stands still
	initial begin
		sclk = 1'b0;
		selN = 1'b1;
		sdi = 1'b0;
	end
	// no reference divider here; the host keeps the detector rate legal
	task automatic xfer(input logic [23:0] f, input logic four, output logic [15:0] rd);
		rd = 16'h0000;
		// move link edges off the system clock's rising edge
		#5;
		selN = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi = (f[23] && i < 16) ? ~sdi : f[i];
			#40 sclk = 1'b1;
			if (i < 16) rd[i] = four ? readLine : dataLine;
			#40 sclk = 1'b0;
		end
		#40 selN = 1'b1;
		#200;
	endtask : xfer
endmodule : serial_host_model

/* File: sim/synth_ctrl_chk.sv */
// port checker for the synthesizer control block
// assumes it is bound onto synth_modulator_control
`timescale 1ns/1ps
module synth_ctrl_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// pins
	input wire logic serialSelectN,
	input wire logic serialDataPinOe,
	input wire logic lockOrReadDataPin,
	input wire logic tuneInWindow,
	input wire logic [1:0] ctrlPinsOut,
	input wire logic [5:0] generalOutputs,
	input wire logic [5:0] pumpCurrent,
	input wire logic [6:0] vcoBand,
	input wire logic analogOn
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	property p_pump_reset; $past(rst) |-> pumpCurrent == 6'h1F; endproperty
	a_pump_reset: assert property (p_pump_reset) else $error("pump not at reset value");
	property p_band_reset; $past(rst) |-> vcoBand == 7'h40 && !analogOn; endproperty
	a_band_reset: assert property (p_band_reset) else $error("band or power after reset");
	// both taken at one edge, answer registered one cycle after the pair is held
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_b_once; s_axi_bvalid |-> !s_axi_awready; endproperty
	a_b_once: assert property (p_b_once) else $error("address taken during answer");
	property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	property p_sel_idle; serialSelectN [*4] |-> !serialDataPinOe; endproperty
	a_sel_idle: assert property (p_sel_idle) else $error("data pin driven outside frame");
	property p_lock_low; (serialSelectN && !tuneInWindow) [*5] |-> !lockOrReadDataPin; endproperty
	a_lock_low: assert property (p_lock_low) else $error("lock without window");
	property p_pins_gpo; ctrlPinsOut == generalOutputs[1:0]; endproperty
	a_pins_gpo: assert property (p_pins_gpo) else $error("control pins not output set");
	// main scenarios reached
	c_wr: cover property (s_axi_bvalid);
	c_on: cover property ($rose(analogOn));
	c_rd: cover property (serialDataPinOe);
endmodule : synth_ctrl_chk

bind synth_modulator_control synth_ctrl_chk synth_ctrl_chk_inst (.clk_sys, .rst,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .serialSelectN, .serialDataPinOe,
	.lockOrReadDataPin, .tuneInWindow, .ctrlPinsOut, .generalOutputs, .pumpCurrent,
	.vcoBand, .analogOn);

/* File: sim/synth_modulator_control_tb.sv */
// self-checking bench for the synthesizer control block
// assumes the host model file and the bound checker are compiled with it
`timescale 1ns/1ps
module synth_modulator_control_tb;
	logic clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, ctrlPinsOut, ctrlPinsOe, mixerGain;
	logic serialClk, serialSelectN, serialDataPinIn, serialDataPinOut, serialDataPinOe, hostSdi;
	logic lockOrReadDataPin, enablePin, bankSelectPin, resetPinN, addressPinA, addressPinB;
	logic vcoFast, tuneInWindow, analogOn, referenceOn;
	logic [5:0] vcoGainCode, pumpCurrent, generalOutputs;
	logic [6:0] vcoBand;
	logic [15:0] sr;
	int n_mismatch = 0;
	int samples_checked = 0;
	// shared data line
	assign serialDataPinIn = serialDataPinOe ? serialDataPinOut : hostSdi;
	synth_modulator_control #(.WARMUP_UNIT_CYCLES(2)) synth_modulator_control_inst (
		.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serialClk, .serialSelectN,
		.serialDataPinIn, .serialDataPinOut, .serialDataPinOe, .lockOrReadDataPin,
		.enablePin, .bankSelectPin, .resetPinN, .addressPinA, .addressPinB, .ctrlPinsOut,
		.ctrlPinsOe, .vcoFast, .tuneInWindow, .vcoGainCode, .analogOn, .referenceOn,
		.vcoBand, .pumpCurrent, .mixerGain, .generalOutputs);
	serial_host_model serial_host_model_inst (.sclk(serialClk), .selN(serialSelectN),
		.sdi(hostSdi), .dataLine(serialDataPinIn), .readLine(lockOrReadDataPin));
	// ------------------------------------------------------------
	// clock, bus tasks
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk_sys);
			// each channel released at the edge that takes it
			if (s_axi_awready === 1'b1) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(ta && tw));
		while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask : axw
	task automatic axr(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask : axr
	task automatic calwait();
		int n;
		n = 0;
		repeat (60) @(posedge clk_sys);
		do begin
			axr(8'h10);
			n++;
		end while (d[10] !== 1'b0 && n < 400);
		// lock flag follows the end of busy by one cycle
		repeat (2) @(posedge clk_sys);
		axr(8'h10);
	endtask : calwait
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// calibration runs
	task automatic t_enable();
		@(posedge clk_sys);
		{vcoFast, tuneInWindow, enablePin} <= 3'h7;
		repeat (6) @(posedge clk_sys);
		chk(32'(analogOn), 32'h1);
		calwait();
		chk(d & 32'h1FF, 32'h1FF);
		vcoFast <= 1'b0;
		axw(8'h08, 32'h40, 2'h0);
		calwait();
		chk(d & 32'h1FF, 32'h180);
		axr(8'h08);
		chk(d, 32'h0);
		{tuneInWindow, enablePin} <= 2'h0;
		repeat (6) @(posedge clk_sys);
		chk(32'(analogOn), 32'h0);
	endtask : t_enable
	task automatic t_pump();
		axw(8'h00, 32'h17F, 2'h0);
		// pump output is registered after the field
		repeat (2) @(posedge clk_sys);
		chk(32'(pumpCurrent), 32'h3F);
		bankSelectPin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk(32'(pumpCurrent), 32'h05);
		axw(8'h00, 32'h117F, 2'h0);
		repeat (4) @(posedge clk_sys);
		chk(32'(pumpCurrent), 32'h35);
		bankSelectPin <= 1'b0;
		axw(8'h00, 32'h7DF, 2'h0);
	endtask : t_pump
	task automatic t_gain();
		for (int g = 0; g < 4; g++) begin
			axw(8'h04, 32'h21 | (32'(g) << 9), 2'h0);
			chk(32'(mixerGain), 32'(g));
		end
		chk(32'(referenceOn), 32'h1);
	endtask : t_gain
	task automatic t_serial();
		serial_host_model_inst.xfer({1'b0, 2'h3, 5'h03, 16'h0A95}, 1'b0, sr);
		axr(8'h0C);
		chk(d, 32'hA95);
		chk(32'(generalOutputs), 32'h15);
		bankSelectPin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk(32'(generalOutputs), 32'h2A);
		bankSelectPin <= 1'b0;
		serial_host_model_inst.xfer({1'b1, 2'h0, 5'h03, 16'h0000}, 1'b0, sr);
		chk(32'(sr), 32'hA95);
		axw(8'h08, 32'h01, 2'h0);
		serial_host_model_inst.xfer({1'b1, 2'h0, 5'h00, 16'h0000}, 1'b1, sr);
		chk(32'(sr), 32'h7DF);
		axw(8'h08, 32'h05, 2'h0);
		serial_host_model_inst.xfer({1'b0, 2'h1, 5'h03, 16'h0111}, 1'b0, sr);
		axr(8'h0C);
		chk(d, 32'hA95);
		serial_host_model_inst.xfer({1'b0, 2'h2, 5'h03, 16'h0111}, 1'b0, sr);
		axr(8'h0C);
		chk(d, 32'h111);
	endtask : t_serial
	task automatic t_soft();
		axw(8'h08, 32'h8A, 2'h0);
		repeat (4) @(posedge clk_sys);
		chk(32'(analogOn), 32'h1);
		chk(32'({ctrlPinsOe, ctrlPinsOut}), 32'hD);
		// calibration must have started from the register enable
		axr(8'h10);
		chk(d & 32'h400, 32'h400);
		// pin raised while software owns enable, must be ignored
		enablePin <= 1'b1;
		axw(8'h08, 32'h02, 2'h0);
		repeat (4) @(posedge clk_sys);
		chk(32'(analogOn), 32'h0);
	endtask : t_soft
	task automatic results();
		$display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	// watchdog against a hang
	initial begin
		#400000;
		n_mismatch++;
		results();
	end
	// main sequence
	initial begin
		{rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
		{enablePin, bankSelectPin, addressPinA, vcoFast, tuneInWindow} = 5'h00;
		{resetPinN, addressPinB} = 2'h3;
		{s_axi_awaddr, s_axi_araddr} = 16'h0000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		vcoGainCode = 6'h0A;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		axr(8'h00);
		chk(d, 32'h7DF);
		axr(8'h04);
		chk(d, 32'h20);
		t_enable();
		t_pump();
		t_gain();
		t_serial();
		t_soft();
		axw(8'h1C, 32'h0, 2'h2);
		results();
	end
endmodule : synth_modulator_control_tb
